// File: hdl/pml_port.sv
// Two 8-bit general purpose ports: data latches, pin readback,
// per-pin mode selects and the port mismatch detector.
// Assumes a processor bus with byte and bit access and an rmw flag.
`timescale 1ns/1ps

// How it works
// RULE_01 - Mismatch when masked pins of either port differ from masked expected value.
// RULE_02 - Compare-select bit 0 makes that pin ignored for mismatch.
// RULE_03 - Compare-select bit 1 compares the pin with its expected bit.
// RULE_04 - Expected bit 0 means expect low, 1 means expect high.
// RULE_05 - Mismatch looks at raw pin levels, regardless of crossbar routing.
// RULE_06 - Mismatch is offered as interrupt request and as wake-up output.
// RULE_07 - Port data writes store into an output latch held until rewritten.
// RULE_08 - Ordinary port data reads return the pin levels.
// RULE_09 - Read-modify-write reads of port data return the latch instead.
// RULE_10 - Port data is reachable as whole bytes and single bits.
// RULE_11 - Each port has per-pin crossbar skip selects.
// RULE_12 - Software should skip analog, plain I/O and dedicated pins.
// RULE_13 - Per-pin input kind select, analog or digital, never automatic.
// RULE_14 - Per-pin output drive select, open-drain or push-pull.
// RULE_15 - SMBus data and clock pins always drive open-drain.
// RULE_16 - Input kind bit 0 is analog, 1 is digital.
// RULE_17 - Analog pins lose pullup, output driver and input receiver.
// RULE_18 - Output drive bit 0 open-drain, 1 push-pull.
// RULE_19 - Skip bit 1 passes pin over, 0 leaves it for the crossbar.
// RULE_20 - Pins synchronised first; mismatch holds while any pin differs.
module pml_port
  import pml_pkg::*;
#(
  parameter int W = PML_W
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [7:0]   bus_addr,
  input  wire logic         bus_wr,
  input  wire logic         bus_rd,
  input  wire logic         bus_bit,
  input  wire logic [2:0]   bus_bit_sel,
  input  wire logic         bus_rmw,
  input  wire logic [W-1:0] bus_wdata,
  output logic      [W-1:0] bus_rdata,
  input  wire logic [W-1:0] p0_pin_in,
  input  wire logic [W-1:0] p1_pin_in,
  input  wire logic [W-1:0] p0_periph_out,
  input  wire logic [W-1:0] p1_periph_out,
  input  wire logic [W-1:0] p0_periph_sel,
  input  wire logic [W-1:0] p1_periph_sel,
  input  wire logic [W-1:0] p0_smbus_pin,
  input  wire logic [W-1:0] p1_smbus_pin,
  input  wire logic         weak_pullup_off,
  output logic      [W-1:0] p0_pin_out,
  output logic      [W-1:0] p0_pin_oe,
  output logic      [W-1:0] p1_pin_out,
  output logic      [W-1:0] p1_pin_oe,
  output logic      [W-1:0] p0_pullup_en,
  output logic      [W-1:0] p1_pullup_en,
  output logic      [W-1:0] p0_receiver_en,
  output logic      [W-1:0] p1_receiver_en,
  output logic      [W-1:0] p0_digital_in,
  output logic      [W-1:0] p1_digital_in,
  output logic      [W-1:0] crossbar_skip_p0,
  output logic      [W-1:0] crossbar_skip_p1,
  output logic              mismatch_irq,
  output logic              mismatch_wake
);

  // ****************************************
  // Registers
  // ****************************************
  logic [W-1:0] p0_latch_reg;
  logic [W-1:0] p1_latch_reg;
  logic [W-1:0] port0_expected_value_reg;
  logic [W-1:0] port0_compare_select_reg;
  logic [W-1:0] port1_expected_value_reg;
  logic [W-1:0] port1_compare_select_reg;
  logic [W-1:0] p0_kind_reg;
  logic [W-1:0] p1_kind_reg;
  logic [W-1:0] p0_drive_reg;
  logic [W-1:0] p1_drive_reg;
  logic [W-1:0] p0_skip_reg;
  logic [W-1:0] p1_skip_reg;
  logic [W-1:0] p0_sync;
  logic [W-1:0] p1_sync;

  // RULE_20 sync pin inputs
  pml_sync #(.W(W)) u_sync0 (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .d        (p0_pin_in),
    .q        (p0_sync)
  );

  pml_sync #(.W(W)) u_sync1 (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .d        (p1_pin_in),
    .q        (p1_sync)
  );

  // ****************************************
  // Bus decode
  // ****************************************
  // Bit accesses touch one lane; byte accesses all lanes
  function automatic logic [W-1:0] lane_mask(input logic is_bit, input logic [2:0] sel);
    logic [W-1:0] m;
    m = '0;
    m[sel] = 1'b1;
    return is_bit ? m : '1;
  endfunction

  // Merge of written data into a register under the lane mask
  function automatic logic [W-1:0] merge(input logic [W-1:0] old, input logic [W-1:0] wd,
                                         input logic [W-1:0] m);
    return (old & ~m) | (wd & m);
  endfunction

  wire [W-1:0] wmask     = lane_mask(bus_bit, bus_bit_sel);
  wire         wr_p0     = bus_wr && (bus_addr == PML_ADDR_P0_DATA);
  wire         wr_p1     = bus_wr && (bus_addr == PML_ADDR_P1_DATA);
  wire         wr_p0_exp = bus_wr && (bus_addr == PML_ADDR_P0_EXPECT);
  wire         wr_p0_sel = bus_wr && (bus_addr == PML_ADDR_P0_SELECT);
  wire         wr_p1_exp = bus_wr && (bus_addr == PML_ADDR_P1_EXPECT);
  wire         wr_p1_sel = bus_wr && (bus_addr == PML_ADDR_P1_SELECT);
  wire         wr_p0_knd = bus_wr && (bus_addr == PML_ADDR_P0_KIND);
  wire         wr_p1_knd = bus_wr && (bus_addr == PML_ADDR_P1_KIND);
  wire         wr_p0_drv = bus_wr && (bus_addr == PML_ADDR_P0_DRIVE);
  wire         wr_p1_drv = bus_wr && (bus_addr == PML_ADDR_P1_DRIVE);
  wire         wr_p0_skp = bus_wr && (bus_addr == PML_ADDR_P0_SKIP);
  wire         wr_p1_skp = bus_wr && (bus_addr == PML_ADDR_P1_SKIP);

  // RULE_08 pins on plain read
  // RULE_09 latch on rmw read
  wire [W-1:0] p0_read = bus_rmw ? p0_latch_reg : p0_sync;
  wire [W-1:0] p1_read = bus_rmw ? p1_latch_reg : p1_sync;

  logic [W-1:0] rd_byte;
  always_comb begin
    unique case (bus_addr)
      PML_ADDR_P0_DATA:   rd_byte = p0_read;
      PML_ADDR_P1_DATA:   rd_byte = p1_read;
      PML_ADDR_P0_EXPECT: rd_byte = port0_expected_value_reg;
      PML_ADDR_P0_SELECT: rd_byte = port0_compare_select_reg;
      PML_ADDR_P1_EXPECT: rd_byte = port1_expected_value_reg;
      PML_ADDR_P1_SELECT: rd_byte = port1_compare_select_reg;
      PML_ADDR_P0_KIND:   rd_byte = p0_kind_reg;
      PML_ADDR_P1_KIND:   rd_byte = p1_kind_reg;
      PML_ADDR_P0_DRIVE:  rd_byte = p0_drive_reg;
      PML_ADDR_P1_DRIVE:  rd_byte = p1_drive_reg;
      PML_ADDR_P0_SKIP:   rd_byte = p0_skip_reg;
      PML_ADDR_P1_SKIP:   rd_byte = p1_skip_reg;
      default:            rd_byte = '0;
    endcase
  end

  // RULE_10 bit read lands in bit 0
  wire [W-1:0] rd_value = bus_bit ? {{(W-1){1'b0}}, rd_byte[bus_bit_sel]} : rd_byte;

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      p0_latch_reg             <= PML_RST_DATA;
      p1_latch_reg             <= PML_RST_DATA;
      port0_expected_value_reg <= PML_RST_EXPECT;
      port0_compare_select_reg <= PML_RST_SELECT;
      port1_expected_value_reg <= PML_RST_EXPECT;
      port1_compare_select_reg <= PML_RST_SELECT;
      p0_kind_reg              <= PML_RST_KIND;
      p1_kind_reg              <= PML_RST_KIND;
      p0_drive_reg             <= PML_RST_DRIVE;
      p1_drive_reg             <= PML_RST_DRIVE;
      p0_skip_reg              <= PML_RST_SKIP;
      p1_skip_reg              <= PML_RST_SKIP;
    end else begin
      // RULE_07 latch holds output value
      // RULE_10 byte or bit write
      if (wr_p0) p0_latch_reg <= merge(p0_latch_reg, bus_wdata, wmask);
      if (wr_p1) p1_latch_reg <= merge(p1_latch_reg, bus_wdata, wmask);
      if (wr_p0_exp) port0_expected_value_reg <= merge(port0_expected_value_reg, bus_wdata, wmask);
      if (wr_p0_sel) port0_compare_select_reg <= merge(port0_compare_select_reg, bus_wdata, wmask);
      if (wr_p1_exp) port1_expected_value_reg <= merge(port1_expected_value_reg, bus_wdata, wmask);
      if (wr_p1_sel) port1_compare_select_reg <= merge(port1_compare_select_reg, bus_wdata, wmask);
      // RULE_13 kind never automatic
      if (wr_p0_knd) p0_kind_reg <= merge(p0_kind_reg, bus_wdata, wmask);
      if (wr_p1_knd) p1_kind_reg <= merge(p1_kind_reg, bus_wdata, wmask);
      // RULE_14 drive never automatic
      if (wr_p0_drv) p0_drive_reg <= merge(p0_drive_reg, bus_wdata, wmask);
      if (wr_p1_drv) p1_drive_reg <= merge(p1_drive_reg, bus_wdata, wmask);
      // RULE_11 per-pin skip
      if (wr_p0_skp) p0_skip_reg <= merge(p0_skip_reg, bus_wdata, wmask);
      if (wr_p1_skp) p1_skip_reg <= merge(p1_skip_reg, bus_wdata, wmask);
    end
  end

  // ****************************************
  // Port match
  // ****************************************
  // RULE_02 mask zero ignored
  // RULE_03 mask one compared
  // RULE_04 expected bit is level
  // RULE_05 raw pins, no crossbar
  wire [W-1:0] p0_diff  = (p0_sync ^ port0_expected_value_reg) & port0_compare_select_reg;
  wire [W-1:0] p1_diff  = (p1_sync ^ port1_expected_value_reg) & port1_compare_select_reg;
  // RULE_01 either port mismatching
  wire         mismatch = (|p0_diff) | (|p1_diff);

  // ****************************************
  // Pin drivers
  // ****************************************
  // Periph selected pins take the peripheral value, else the latch
  wire [W-1:0] p0_val = (p0_periph_sel & p0_periph_out) | (~p0_periph_sel & p0_latch_reg);
  wire [W-1:0] p1_val = (p1_periph_sel & p1_periph_out) | (~p1_periph_sel & p1_latch_reg);
  // RULE_15 smbus forces open-drain
  // RULE_18 drive 1 push-pull
  wire [W-1:0] p0_pp  = p0_drive_reg & ~p0_smbus_pin;
  wire [W-1:0] p1_pp  = p1_drive_reg & ~p1_smbus_pin;
  // RULE_16 kind 1 digital
  // RULE_17 analog drops driver
  wire [W-1:0] p0_oe  = p0_kind_reg & (p0_pp | ~p0_val);
  wire [W-1:0] p1_oe  = p1_kind_reg & (p1_pp | ~p1_val);
  // RULE_17 analog drops pullup
  wire [W-1:0] p0_pu  = p0_kind_reg & {W{~weak_pullup_off}};
  wire [W-1:0] p1_pu  = p1_kind_reg & {W{~weak_pullup_off}};

  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata        <= '0;
      p0_pin_out       <= PML_RST_DATA;
      p1_pin_out       <= PML_RST_DATA;
      p0_pin_oe        <= '0;
      p1_pin_oe        <= '0;
      p0_pullup_en     <= '0;
      p1_pullup_en     <= '0;
      p0_receiver_en   <= PML_RST_KIND;
      p1_receiver_en   <= PML_RST_KIND;
      p0_digital_in    <= '0;
      p1_digital_in    <= '0;
      crossbar_skip_p0 <= PML_RST_SKIP;
      crossbar_skip_p1 <= PML_RST_SKIP;
      mismatch_irq     <= 1'b0;
      mismatch_wake    <= 1'b0;
    end else begin
      if (bus_rd) bus_rdata <= rd_value;
      p0_pin_out       <= p0_val;
      p1_pin_out       <= p1_val;
      p0_pin_oe        <= p0_oe;
      p1_pin_oe        <= p1_oe;
      p0_pullup_en     <= p0_pu;
      p1_pullup_en     <= p1_pu;
      // RULE_17 analog drops receiver
      p0_receiver_en   <= p0_kind_reg;
      p1_receiver_en   <= p1_kind_reg;
      p0_digital_in    <= p0_sync & p0_kind_reg;
      p1_digital_in    <= p1_sync & p1_kind_reg;
      // RULE_19 skip 1 passes over
      crossbar_skip_p0 <= p0_skip_reg;
      crossbar_skip_p1 <= p1_skip_reg;
      // RULE_06 irq and wake
      // RULE_20 level while differing
      mismatch_irq     <= mismatch;
      mismatch_wake    <= mismatch;
    end
  end

endmodule // pml_port

// File: hdl/pml_pkg.sv
// Constants for the port match and latch block.
// Assumes an 8-bit special function register bus with separate bit access.
package pml_pkg;
  localparam int PML_W = 8;
  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [7:0] PML_ADDR_P0_DATA    = 8'h80;
  localparam logic [7:0] PML_ADDR_P1_DATA    = 8'h90;
  localparam logic [7:0] PML_ADDR_P1_EXPECT  = 8'he1;
  localparam logic [7:0] PML_ADDR_P1_SELECT  = 8'he2;
  localparam logic [7:0] PML_ADDR_P0_EXPECT  = 8'hf3;
  localparam logic [7:0] PML_ADDR_P0_SELECT  = 8'hf4;
  localparam logic [7:0] PML_ADDR_P0_KIND    = 8'hf1;
  localparam logic [7:0] PML_ADDR_P1_KIND    = 8'hf2;
  localparam logic [7:0] PML_ADDR_P0_DRIVE   = 8'ha4;
  localparam logic [7:0] PML_ADDR_P1_DRIVE   = 8'ha5;
  localparam logic [7:0] PML_ADDR_P0_SKIP    = 8'hd4;
  localparam logic [7:0] PML_ADDR_P1_SKIP    = 8'hd5;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] PML_RST_DATA   = 8'hff;
  localparam logic [7:0] PML_RST_EXPECT = 8'hff;
  localparam logic [7:0] PML_RST_SELECT = 8'h00;
  localparam logic [7:0] PML_RST_KIND   = 8'hff;
  localparam logic [7:0] PML_RST_DRIVE  = 8'h00;
  localparam logic [7:0] PML_RST_SKIP   = 8'h00;
endpackage

// File: hdl/pml_sync.sv
// Two-flop synchroniser for one port's pin inputs.
// Assumes core_clk; first stage read only by second.
`timescale 1ns/1ps
module pml_sync
  import pml_pkg::*;
#(
  parameter int W = PML_W
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule // pml_sync

// File: dv/pml_monitor.sv
// Port match and latch checker, bound to pml_port.
// Assumes select, expected and port 0 data are written as whole bytes.
`timescale 1ns/1ps
module pml_monitor
  import pml_pkg::*;
#(
  parameter int W = PML_W
) (
  input wire logic         core_clk,
  input wire logic         rst_n,
  input wire logic [7:0]   bus_addr,
  input wire logic         bus_wr,
  input wire logic         bus_rd,
  input wire logic         bus_bit,
  input wire logic         bus_rmw,
  input wire logic [W-1:0] bus_wdata,
  input wire logic [W-1:0] bus_rdata,
  input wire logic [W-1:0] p0_pin_in,
  input wire logic [W-1:0] p1_pin_in,
  input wire logic [W-1:0] p0_periph_sel,
  input wire logic [W-1:0] p0_smbus_pin,
  input wire logic [W-1:0] p0_pin_out,
  input wire logic [W-1:0] p0_pin_oe,
  input wire logic [W-1:0] p0_pullup_en,
  input wire logic [W-1:0] p0_receiver_en,
  input wire logic [W-1:0] p0_digital_in,
  input wire logic [W-1:0] crossbar_skip_p0,
  input wire logic         mismatch_irq,
  input wire logic         mismatch_wake
);
  // ****
  // Register shadows
  // ****
  logic [W-1:0] e0, s0, e1, s1, d0;
  logic [2:0]   up;
  wire          wb = bus_wr && !bus_bit;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {e0, e1, s0, s1} <= {PML_RST_EXPECT, PML_RST_EXPECT, PML_RST_SELECT, PML_RST_SELECT};
      d0 <= PML_RST_DATA;
      up <= 3'h0;
    end else begin
      if (up != 3'h7) up <= up + 3'h1;
      if (wb && bus_addr == PML_ADDR_P0_EXPECT) e0 <= bus_wdata;
      if (wb && bus_addr == PML_ADDR_P0_SELECT) s0 <= bus_wdata;
      if (wb && bus_addr == PML_ADDR_P1_EXPECT) e1 <= bus_wdata;
      if (wb && bus_addr == PML_ADDR_P1_SELECT) s1 <= bus_wdata;
      if (wb && bus_addr == PML_ADDR_P0_DATA) d0 <= bus_wdata;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Sync takes two edges, output register one more
  a_mismatch_calc: assert property (up >= 3'h4 |-> mismatch_irq ==
    (|(($past(p0_pin_in, 3) ^ $past(e0)) & $past(s0)) || |(($past(p1_pin_in, 3) ^ $past(e1)) & $past(s1))))
    else $error("mismatch level wrong");
  a_wake_pair: assert property (mismatch_wake == mismatch_irq)
    else $error("wake differs from irq");
  a_read_pins: assert property (bus_rd && !bus_rmw && !bus_bit && bus_addr == PML_ADDR_P0_DATA
    |=> bus_rdata == $past(p0_pin_in, 3)) else $error("port read not pins");
  a_rmw_latch: assert property (bus_rd && bus_rmw && !bus_bit && bus_addr == PML_ADDR_P0_DATA
    |=> bus_rdata == $past(d0)) else $error("rmw read not latch");
  a_latch_drive: assert property (wb && bus_addr == PML_ADDR_P0_DATA && p0_periph_sel == '0
    |-> ##2 p0_pin_out == $past(bus_wdata, 2)) else $error("latch not driven");
  a_bit_read: assert property (bus_rd && bus_bit |=> bus_rdata[W-1:1] == '0)
    else $error("bit read upper bits set");
  a_analog_off: assert property (((p0_pullup_en | p0_pin_oe | p0_digital_in)
    & ~p0_receiver_en & ~$past(p0_receiver_en)) == '0) else $error("analog pin active");
  a_smbus_od: assert property ((p0_smbus_pin & $past(p0_smbus_pin) & $past(p0_smbus_pin, 2)
    & p0_pin_oe & p0_pin_out) == '0) else $error("smbus pin drives high");
  a_skip_follow: assert property (wb && bus_addr == PML_ADDR_P0_SKIP
    |-> ##2 crossbar_skip_p0 == $past(bus_wdata, 2)) else $error("skip not applied");
  c_mismatch: cover property ($rose(mismatch_irq));
  c_rmw: cover property (bus_rd && bus_rmw);
  c_bit: cover property (bus_rd && bus_bit);
endmodule // pml_monitor

bind pml_port pml_monitor #(.W(W)) i_pml_monitor (.core_clk, .rst_n, .bus_addr, .bus_wr, .bus_rd,
  .bus_bit, .bus_rmw, .bus_wdata, .bus_rdata, .p0_pin_in, .p1_pin_in, .p0_periph_sel,
  .p0_smbus_pin, .p0_pin_out, .p0_pin_oe, .p0_pullup_en, .p0_receiver_en, .p0_digital_in,
  .crossbar_skip_p0, .mismatch_irq, .mismatch_wake);

// File: dv/pml_pin_model.sv
// External pin model: resolves device drive, outside drive and pullup.
// Assumes the device drive always wins over the outside driver.
`timescale 1ns/1ps
module pml_pin_model
  import pml_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic [PML_W-1:0] drv_out,
  input  wire logic [PML_W-1:0] drv_oe,
  input  wire logic [PML_W-1:0] pull_en,
  input  wire logic [PML_W-1:0] ext_val,
  input  wire logic [PML_W-1:0] ext_en,
  output logic      [PML_W-1:0] level
);
  // Floating pins toggle so no stale level is read
  logic [PML_W-1:0] flt = 8'h55;
  always @(posedge core_clk) flt <= ~flt;
  assign level = (drv_oe & drv_out) | (~drv_oe & ext_en & ext_val)
               | (~drv_oe & ~ext_en & (pull_en | flt));
endmodule // pml_pin_model

// File: dv/test_port_match_and_latch.sv
// Testbench for pml_port: byte and bit register accesses, pin model.
// Assumes periph routing idle; pins driven from outside unless stated.
`timescale 1ns/1ps
module test_port_match_and_latch import pml_pkg::*;;
  logic       core_clk = 1'b0, rst_n = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
  logic       bus_bit = 1'b0, bus_rmw = 1'b0, weak_pullup_off = 1'b0;
  logic [2:0] bus_bit_sel = 3'h0;
  logic [7:0] bus_addr = 8'h00, bus_wdata = 8'h00, bus_rdata, ext0 = 8'hff, ext1 = 8'hff;
  logic [7:0] p0_smbus_pin = 8'h00, p0_pin_in, p1_pin_in, p0_pin_out, p0_pin_oe, p1_pin_out;
  logic [7:0] p0_periph_out = 8'h00, p0_periph_sel = 8'h00;
  logic [7:0] p1_pin_oe, p0_pullup_en, p1_pullup_en, p0_receiver_en, crossbar_skip_p0;
  logic       mismatch_irq, mismatch_wake;
  int         miscompares = 0, total_checks = 0;
  logic [7:0] ra [8] = '{PML_ADDR_P0_EXPECT, PML_ADDR_P0_SELECT, PML_ADDR_P1_EXPECT,
    PML_ADDR_P1_SELECT, PML_ADDR_P0_SKIP, PML_ADDR_P0_KIND, PML_ADDR_P0_DRIVE, 8'h00};
  logic [7:0] re [8] = '{8'hff, 8'h00, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
  always #12.5 core_clk = ~core_clk;
  pml_port i_pml_port (.core_clk, .rst_n, .bus_addr, .bus_wr, .bus_rd, .bus_bit, .bus_bit_sel,
    .bus_rmw, .bus_wdata, .bus_rdata, .p0_pin_in, .p1_pin_in, .p0_periph_out,
    .p1_periph_out(8'h00), .p0_periph_sel, .p1_periph_sel(8'h00), .p0_smbus_pin,
    .p1_smbus_pin(8'h00), .weak_pullup_off, .p0_pin_out, .p0_pin_oe, .p1_pin_out, .p1_pin_oe,
    .p0_pullup_en, .p1_pullup_en, .p0_receiver_en, .p1_receiver_en(), .p0_digital_in(),
    .p1_digital_in(), .crossbar_skip_p0, .crossbar_skip_p1(), .mismatch_irq, .mismatch_wake);
  pml_pin_model i_pml_pin_model_p0 (.core_clk, .drv_out(p0_pin_out), .drv_oe(p0_pin_oe),
    .pull_en(p0_pullup_en), .ext_val(ext0), .ext_en(8'hff), .level(p0_pin_in));
  pml_pin_model i_pml_pin_model_p1 (.core_clk, .drv_out(p1_pin_out), .drv_oe(p1_pin_oe),
    .pull_en(p1_pullup_en), .ext_val(ext1), .ext_en(8'hff), .level(p1_pin_in));
  // ****
  // Tasks
  // ****
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, d, input logic b = 1'b0, input logic [2:0] s = 3'h0);
    @(posedge core_clk);
    {bus_addr, bus_wdata, bus_bit, bus_bit_sel} <= {a, d, b, s};
    bus_wr <= 1'b1;
    @(posedge core_clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic m, b, input logic [2:0] s,
                    input logic [7:0] e);
    @(posedge core_clk);
    {bus_addr, bus_rmw, bus_bit, bus_bit_sel} <= {a, m, b, s};
    bus_rd <= 1'b1;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    #1 chk("bus_rdata", e, bus_rdata);
  endtask
  // Mismatch settles within a few edges of its cause
  task automatic wmm(input logic e);
    for (int n = 0; n < 10 && mismatch_irq !== e; n++) @(posedge core_clk);
    chk("mismatch_irq", {7'h00, e}, {7'h00, mismatch_irq});
    chk("mismatch_wake", {7'h00, e}, {7'h00, mismatch_wake});
    if (mismatch_irq !== e) close_out();
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rd(ra[i], 1'b0, 1'b0, 3'h0, re[i]);
    $display("test reset values done");
    wr(PML_ADDR_P0_SELECT, 8'h01);
    wmm(1'b0);
    @(posedge core_clk) ext0 <= 8'hfe;
    wmm(1'b1);
    wr(PML_ADDR_P0_EXPECT, 8'hfe);
    wmm(1'b0);
    wr(PML_ADDR_P0_EXPECT, 8'hff);
    wmm(1'b1);
    wr(PML_ADDR_P0_SELECT, 8'h00);
    wmm(1'b0);
    wr(PML_ADDR_P1_SELECT, 8'h80);
    wr(PML_ADDR_P1_EXPECT, 8'h7f);
    wmm(1'b1);
    @(posedge core_clk) ext1 <= 8'h7f;
    wmm(1'b0);
    $display("test mismatch done");
    @(posedge core_clk) ext0 <= 8'h0f;
    wr(PML_ADDR_P0_DATA, 8'h5a);
    repeat (4) @(posedge core_clk);
    chk("p0_pin_out", 8'h5a, p0_pin_out);
    rd(PML_ADDR_P0_DATA, 1'b0, 1'b0, 3'h0, 8'h0a);
    rd(PML_ADDR_P0_DATA, 1'b1, 1'b0, 3'h0, 8'h5a);
    wr(PML_ADDR_P1_DATA, 8'h00, 1'b1, 3'h3);
    rd(PML_ADDR_P1_DATA, 1'b1, 1'b1, 3'h3, 8'h00);
    wr(PML_ADDR_P1_DATA, 8'h08, 1'b1, 3'h3);
    rd(PML_ADDR_P1_DATA, 1'b1, 1'b1, 3'h3, 8'h01);
    rd(PML_ADDR_P1_DATA, 1'b1, 1'b0, 3'h0, 8'hff);
    $display("test latch done");
    wr(PML_ADDR_P0_DATA, 8'hff);
    @(posedge core_clk) p0_smbus_pin <= 8'hf0;
    wr(PML_ADDR_P0_DRIVE, 8'hff);
    repeat (2) @(posedge core_clk);
    chk("p0_pin_oe", 8'h0f, p0_pin_oe);
    wr(PML_ADDR_P0_DRIVE, 8'h00);
    repeat (2) @(posedge core_clk);
    chk("p0_pin_oe", 8'h00, p0_pin_oe);
    wr(PML_ADDR_P0_KIND, 8'hf0);
    repeat (2) @(posedge core_clk);
    chk("p0_receiver_en", 8'hf0, p0_receiver_en);
    chk("p0_pullup_en", 8'hf0, p0_pullup_en);
    @(posedge core_clk) weak_pullup_off <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("p0_pullup_en", 8'h00, p0_pullup_en);
    // Skip the analog and plain pins
    wr(PML_ADDR_P0_SKIP, 8'h8f);
    repeat (2) @(posedge core_clk);
    chk("crossbar_skip_p0", 8'h8f, crossbar_skip_p0);
    // Routed pin takes the peripheral value, others keep the latch
    @(posedge core_clk) {p0_periph_sel, p0_periph_out} <= {8'h01, 8'h00};
    repeat (2) @(posedge core_clk);
    chk("p0_pin_out", 8'hfe, p0_pin_out);
    $display("test modes done");
    close_out();
  end
endmodule // test_port_match_and_latch
